// [logic/ibl_pkg.sv]
package ibl_pkg;
    // Register map
    localparam int          ADDR_W   = 20;
    localparam logic [19:0] CTL_OFF  = 20'h1_d140;
    localparam logic [19:0] STAT_OFF = 20'h1_d144;

    // Boot control fields
    localparam int CHAIN_B = 31;
    localparam int ASZ_B   = 30;
    localparam int PINC_B  = 29;
    localparam int UNLK_B  = 28;
    localparam int BA_HI   = 22;
    localparam int BA_LO   = 16;
    localparam int PA_HI   = 12;
    localparam int PA_SH   = 4;
    localparam logic [31:0] CTL_RW_MASK   = 32'hf07f_ffff;
    localparam logic [31:0] CTL_LOCK_MASK = 32'h0003_0000;

    // Load stream: count header, 8-byte records
    localparam logic [2:0]  HDR_LAST  = 3'h1;
    localparam logic [2:0]  REC_LAST  = 3'h7;
    localparam logic [7:0]  ADDR_WRAP = 8'hff;
    localparam logic [3:0]  ACK_BIT   = 4'h8;
    localparam logic [15:0] CNT_ONE   = 16'h0001;

    // Quarter phases of one bus bit
    localparam logic [1:0] Q_SET  = 2'h0;
    localparam logic [1:0] Q_RISE = 2'h1;
    localparam logic [1:0] Q_SAMP = 2'h2;
    localparam logic [1:0] Q_FALL = 2'h3;

    // Quarter count rounds up so the bus never runs fast
    localparam int CLK_NS  = 25;
    localparam int BIT_NS  = 10000;
    localparam int QTR_CYC = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);

    typedef enum logic [3:0] {
        C_INIT, C_START, C_DEVW, C_AHI, C_ALO, C_RSTART, C_DEVR, C_READ, C_STOP, C_DONE
    } ibl_ctl_t;
endpackage : ibl_pkg

// [logic/ibl_stream_if.sv]
`timescale 1ns/1ps
interface ibl_stream_if #(
    parameter int W = 64
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ibl_stream_if

// [logic/ibl_sync.sv]
`timescale 1ns/1ps
module ibl_sync #(
    parameter int           W   = 4,
    parameter logic [W-1:0] RST = '1
) (
    input  logic         clk,
    input  logic         rst_n,
    input  logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ibl_sync_st_t;

    ibl_sync_st_t r;
    ibl_sync_st_t n;

    ////////////////////////////////////////////////////////////////////////
    // Moves when stages two and three agree
    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q  = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.q);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{s1: RST, s2: RST, s3: RST, q: RST};
        end else begin
            r <= n;
        end
    end

    assign dout = r.q;
endmodule : ibl_sync

// [logic/ibl_skid.sv]
`timescale 1ns/1ps
module ibl_skid #(
    parameter int W = 64
) (
    input  logic      clk,
    input  logic      rst_n,
    ibl_stream_if.snk in_s,
    ibl_stream_if.src out_s
);
    typedef struct packed {
        logic [W-1:0] o_d;
        logic         o_v;
        logic [W-1:0] s_d;
        logic         s_v;
    } ibl_skid_st_t;

    ibl_skid_st_t r;
    ibl_skid_st_t n;
    logic         pop;
    logic         push;

    ////////////////////////////////////////////////////////////////////////
    // Output entry plus one spare
    always_comb begin
        n    = r;
        pop  = r.o_v & out_s.ready;
        push = in_s.valid & ~r.s_v;
        if (pop) begin
            if (r.s_v) begin
                n.o_d = r.s_d;
                n.s_v = 1'b0;
            end else begin
                n.o_v = 1'b0;
            end
        end
        if (push) begin
            if (!n.o_v) begin
                n.o_d = in_s.data;
                n.o_v = 1'b1;
            end else begin
                n.s_d = in_s.data;
                n.s_v = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign in_s.ready = ~r.s_v;
    assign out_s.valid = r.o_v;
    assign out_s.data  = r.o_d;
endmodule : ibl_skid

// [logic/ibl_boot_ctrl.sv]
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module ibl_boot_ctrl
#(
    parameter int         QTR_CYCLES  = ibl_pkg::QTR_CYC,
    parameter logic [4:0] BOOT_DEV_HI = 5'h14,
    parameter logic       ASZ_RST     = 1'b0
) (
    input  logic        clk,
    input  logic        rst_n,
    input  logic [ibl_pkg::ADDR_W-1:0] reg_addr,
    input  logic [31:0] reg_wdata,
    input  logic        reg_wr,
    input  logic        reg_rd,
    output logic [31:0] reg_rdata,
    input  logic [1:0]  boot_addr_strap,
    input  logic        scl_in,
    output logic        scl_out,
    output logic        scl_oe_n,
    input  logic        sda_in,
    output logic        sda_out,
    output logic        sda_oe_n,
    output logic        cfg_valid,
    input  logic        cfg_ready,
    output logic [31:0] cfg_addr,
    output logic [31:0] cfg_data,
    output logic        boot_busy,
    output logic        boot_done
);
    import ibl_pkg::*;

    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] rdata;
        ibl_ctl_t    st;
        logic [1:0]  q;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic [15:0] div;
        logic [6:0]  dev;
        logic [15:0] wa;
        logic        psz;
        logic        page_select_increment_en;
        logic        hdr;
        logic [2:0]  bidx;
        logic [15:0] cnt;
        logic [15:0] nrec;
        logic [63:0] rec;
        logic        pend;
        logic        chain_pend;
        logic        to_read;
        logic        last;
        logic        wrapf;
        logic        busy;
        logic        done;
        logic        err;
        logic        scl_oe_n;
        logic        sda_oe_n;
        logic        pad_o;
    } ibl_main_st_t;

    localparam logic [31:0] CTL_RST = {2'h0, 1'b1, 1'b0, 5'h00, BOOT_DEV_HI, 2'h0, 16'h0000};

    ibl_main_st_t r;
    ibl_main_st_t n;
    logic [3:0]   sync_q;
    logic         scl_s;
    logic         sda_s;
    logic [1:0]   strap_s;
    logic         tick;
    logic         go;
    logic         reload;
    logic         end_now;
    logic         wrap_now;
    logic [7:0]   txb;
    logic [63:0]  full;
    logic [31:0]  status;

    ibl_stream_if #(.W(64)) rec_in ();
    ibl_stream_if #(.W(64)) rec_out ();

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    ibl_sync #(.W(4), .RST(4'hf)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({boot_addr_strap, scl_in, sda_in}),
        .dout  (sync_q)
    );

    assign scl_s   = sync_q[1];
    assign sda_s   = sync_q[0];
    assign strap_s = sync_q[3:2];

    // Records leave via a two-entry buffer
    ibl_skid #(.W(64)) u_skid (
        .clk   (clk),
        .rst_n (rst_n),
        .in_s  (rec_in),
        .out_s (rec_out)
    );

    assign rec_in.valid  = r.pend;
    assign rec_in.data   = r.rec;
    assign rec_out.ready = cfg_ready;

    ////////////////////////////////////////////////////////////////////////
    // Store a write; strap bits need unlock
    function automatic logic [31:0] ctl_wr(input logic [31:0] o, input logic [31:0] w);
        logic [31:0] v;
        v = (o & ~CTL_RW_MASK) | (w & CTL_RW_MASK);
        if (!w[UNLK_B]) begin
            v = (v & ~CTL_LOCK_MASK) | (o & CTL_LOCK_MASK);
        end
        return v;
    endfunction : ctl_wr

    // Start byte address from the field
    function automatic logic [15:0] wa_init(input logic [31:0] c);
        if (c[ASZ_B]) begin
            return {c[PA_HI:0], 3'h0};
        end
        return {8'h00, c[PA_SH:0], 3'h0};
    endfunction : wa_init

    ////////////////////////////////////////////////////////////////////////
    // Byte to send in the address phases
    always_comb begin
        case (r.st)
            C_DEVW:  txb = {r.dev, 1'b0};
            C_AHI:   txb = r.wa[15:8];
            C_ALO:   txb = r.wa[7:0];
            C_DEVR:  txb = {r.dev, 1'b1};
            default: txb = 8'h00;
        endcase
    end

    assign full   = {r.rec[55:0], r.sh};
    assign status = {r.nrec, 1'b0, r.dev, 5'h00, r.err, r.done, r.busy};

    // End of device data, or page wrap
    assign end_now  = r.hdr ? (r.bidx == HDR_LAST && {r.cnt[7:0], r.sh} == 16'h0000)
                            : (r.bidx == REC_LAST && r.cnt == CNT_ONE);
    assign wrap_now = ~r.psz & r.page_select_increment_en & (r.wa[7:0] == ADDR_WRAP);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and bus bit engine
    always_comb begin
        n      = r;
        reload = 1'b0;
        tick   = (r.div == 16'(QTR_CYCLES - 1));
        n.div  = tick ? 16'h0000 : r.div + 16'h0001;
        // A pending record stalls the bus, clock low
        go     = tick & ~r.pend;
        n.rdata = 32'h0000_0000;
        if (r.pend && rec_in.ready) begin
            n.pend = 1'b0;
        end
        if (reg_rd) begin
            case (reg_addr)
                CTL_OFF:  n.rdata = r.ctl & CTL_RW_MASK;
                STAT_OFF: n.rdata = status;
                default:  n.rdata = 32'h0000_0000;
            endcase
        end
        // Software writes only store
        if (reg_wr && reg_addr == CTL_OFF) begin
            n.ctl = ctl_wr(r.ctl, reg_wdata);
        end
        if (go && r.st != C_DONE) begin
            n.q = r.q + 2'h1;
            // Clock stretching
            if (r.q == Q_RISE && !scl_s) begin
                n.q = r.q;
            end
            case (r.st)
                C_INIT: begin
                    n.ctl[BA_LO+1:BA_LO] = strap_s;
                    n.busy = 1'b1;
                    n.q    = Q_SET;
                    reload = 1'b1;
                    n.st   = C_START;
                end
                C_START, C_RSTART: begin
                    case (r.q)
                        Q_SET: begin
                            n.scl_oe_n = 1'b0;
                            n.sda_oe_n = 1'b1;
                        end
                        Q_RISE: begin
                            n.scl_oe_n = 1'b1;
                        end
                        Q_SAMP: begin
                            n.sda_oe_n = 1'b0;
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.st = (r.st == C_RSTART && r.to_read) ? C_DEVR : C_DEVW;
                        end
                    endcase
                end
                C_STOP: begin
                    case (r.q)
                        Q_SET: begin
                            n.scl_oe_n = 1'b0;
                            n.sda_oe_n = 1'b0;
                        end
                        Q_RISE: begin
                            n.scl_oe_n = 1'b1;
                        end
                        Q_SAMP: begin
                            n.sda_oe_n = 1'b1;
                        end
                        default: begin
                            if (r.chain_pend) begin
                                n.ctl[CHAIN_B] = 1'b0;
                                n.chain_pend = 1'b0;
                                reload = 1'b1;
                                n.st = C_START;
                            end else begin
                                n.busy = 1'b0;
                                n.done = 1'b1;
                                n.st   = C_DONE;
                            end
                        end
                    endcase
                end
                default: begin
                    case (r.q)
                        Q_SET: begin
                            n.scl_oe_n = 1'b0;
                            if (r.st != C_READ) begin
                                n.sda_oe_n = (r.bitn == ACK_BIT) ? 1'b1 : txb[3'(7 - r.bitn)];
                            end else if (r.bitn != ACK_BIT) begin
                                n.sda_oe_n = 1'b1;
                            end else begin
                                // NACK ends the read
                                n.last     = end_now | wrap_now;
                                n.wrapf    = wrap_now & ~end_now;
                                n.sda_oe_n = end_now | wrap_now;
                            end
                        end
                        Q_RISE: begin
                            n.scl_oe_n = 1'b1;
                        end
                        Q_SAMP: begin
                            if (r.st != C_READ && r.bitn == ACK_BIT) begin
                                n.err = sda_s;
                            end else if (r.st == C_READ && r.bitn != ACK_BIT) begin
                                n.sh = {r.sh[6:0], sda_s};
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.bitn = r.bitn + 4'h1;
                            if (r.bitn == ACK_BIT) begin
                                n.bitn = 4'h0;
                                case (r.st)
                                    C_DEVW: n.st = r.err ? C_STOP : (r.psz ? C_AHI : C_ALO);
                                    C_AHI:  n.st = r.err ? C_STOP : C_ALO;
                                    C_ALO: begin
                                        n.to_read = 1'b1;
                                        n.st = r.err ? C_STOP : C_RSTART;
                                    end
                                    C_DEVR: n.st = r.err ? C_STOP : C_READ;
                                    default: begin
                                        n.wa = r.wa + 16'h0001;
                                        if (r.hdr) begin
                                            n.cnt = {r.cnt[7:0], r.sh};
                                            n.bidx = r.bidx + 3'h1;
                                            if (r.bidx == HDR_LAST) begin
                                                n.hdr  = 1'b0;
                                                n.bidx = 3'h0;
                                            end
                                        end else begin
                                            n.rec  = full;
                                            n.bidx = r.bidx + 3'h1;
                                            if (r.bidx == REC_LAST) begin
                                                n.cnt  = r.cnt - CNT_ONE;
                                                n.nrec = r.nrec + 16'h0001;
                                                if (full[63:32] == {12'h000, CTL_OFF}) begin
                                                    n.ctl = ctl_wr(n.ctl, full[31:0]);
                                                end else begin
                                                    n.pend = 1'b1;
                                                end
                                            end
                                        end
                                        if (r.last && !r.wrapf) begin
                                            // Chain at count end only
                                            n.chain_pend = n.ctl[CHAIN_B];
                                            n.st = C_STOP;
                                        end else if (r.last) begin
                                            n.dev[2:0] = r.dev[2:0] + 3'h1;
                                            n.to_read  = 1'b0;
                                            n.st       = C_RSTART;
                                        end
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            endcase
        end
        // Working copies, start and chain
        if (reload) begin
            n.dev     = n.ctl[BA_HI:BA_LO];
            n.psz     = n.ctl[ASZ_B];
            n.page_select_increment_en    = n.ctl[PINC_B];
            n.wa      = wa_init(n.ctl);
            n.hdr     = 1'b1;
            n.bidx    = 3'h0;
            n.bitn    = 4'h0;
            n.to_read = 1'b0;
            n.err     = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.ctl      <= CTL_RST | {1'b0, ASZ_RST, 30'h0000_0000};
            r.st       <= C_INIT;
            r.hdr      <= 1'b1;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs from flip-flops
    assign reg_rdata = r.rdata;
    assign scl_out   = r.pad_o;
    assign sda_out   = r.pad_o;
    assign scl_oe_n  = r.scl_oe_n;
    assign sda_oe_n  = r.sda_oe_n;
    assign cfg_valid = rec_out.valid;
    assign cfg_addr  = rec_out.data[63:32];
    assign cfg_data  = rec_out.data[31:0];
    assign boot_busy = r.busy;
    assign boot_done = r.done;
endmodule : ibl_boot_ctrl

// [verif/ibl_boot_ctrl_asserts.sv]
`timescale 1ns/1ps
module ibl_boot_ctrl_asserts
    import ibl_pkg::*;
#(
    parameter int QTR_CYCLES = QTR_CYC
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              scl_out,
    input wire logic              scl_oe_n,
    input wire logic              sda_out,
    input wire logic              sda_oe_n,
    input wire logic              cfg_valid,
    input wire logic              cfg_ready,
    input wire logic [31:0]       cfg_addr,
    input wire logic [31:0]       cfg_data,
    input wire logic              boot_busy,
    input wire logic              boot_done
);
    logic [7:0] since_rst_reg;

    // Cycles since reset, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rst_reg <= 8'h00;
        end else if (since_rst_reg != 8'hff) begin
            since_rst_reg <= since_rst_reg + 8'h01;
        end
    end

    ////////////////////////////////////////
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Register port, record output, bus release and load start
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("stray read data");
    chk_unmapped_zero: assert property (reg_rd && reg_addr != CTL_OFF && reg_addr != STAT_OFF
        |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
    chk_reserved_zero: assert property (reg_rd && reg_addr == CTL_OFF |=> reg_rdata[27:23] == 5'h00)
        else $error("reserved bits set");
    chk_ctl_writeback: assert property (reg_wr && reg_addr == CTL_OFF && reg_wdata[UNLK_B] && boot_done
        ##1 reg_rd && reg_addr == CTL_OFF |=> reg_rdata == ($past(reg_wdata, 2) & CTL_RW_MASK))
        else $error("control write not stored");
    chk_cfg_hold: assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_addr) && $stable(cfg_data))
        else $error("record changed in stall");
    chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("bus outputs not driven low");
    chk_bus_free: assert property (boot_done && $past(boot_done, 20) |-> scl_oe_n && sda_oe_n)
        else $error("bus held after load end");
    chk_done_sticky: assert property (boot_done |=> boot_done && !boot_busy)
        else $error("done dropped");
    chk_start_early: assert property (int'(since_rst_reg) < QTR_CYCLES - 1 |-> !boot_busy && !boot_done)
        else $error("load started too early");
    chk_start_late: assert property (int'(since_rst_reg) == QTR_CYCLES + 3 |-> boot_busy)
        else $error("load did not start");

    cov_accept: cover property (cfg_valid && cfg_ready);
    cov_stall: cover property (cfg_valid && !cfg_ready ##1 cfg_valid && !cfg_ready);
    cov_done: cover property ($rose(boot_done));
endmodule : ibl_boot_ctrl_asserts

bind ibl_boot_ctrl ibl_boot_ctrl_asserts #(.QTR_CYCLES(QTR_CYCLES)) ibl_boot_ctrl_asserts_inst (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .scl_out, .scl_oe_n, .sda_out,
    .sda_oe_n, .cfg_valid, .cfg_ready, .cfg_addr, .cfg_data, .boot_busy, .boot_done
);

// [verif/ibl_eeprom_model.sv]
`timescale 1ns/1ps
module ibl_eeprom_model (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic slow,
    output logic      sda_pull,
    output logic      scl_hold
);
    logic [7:0]  mem [0:2047];
    logic [7:0]  sh_reg, cur_reg;
    logic [10:0] ptr_reg;
    logic [3:0]  bn_reg = 4'h0;
    logic [1:0]  ph_reg = 2'h3;
    logic        rd_reg, sel_reg, nak_reg;

    initial sda_pull = 1'b0;
    initial scl_hold = 1'b0;

    ////////////////////////////////////////
    // Start or restart
    always @(negedge sda) begin
        if (scl) begin
            ph_reg = 2'h0;
            bn_reg = 4'h0;
            nak_reg = 1'b0;
            rd_reg = 1'b0;
        end
    end

    // Stop ends the transfer
    always @(posedge sda) begin
        if (scl) begin
            ph_reg = 2'h3;
        end
    end

    // Bits taken on SCL rise; ninth is the ack
    always @(posedge scl) begin
        if (ph_reg != 2'h3) begin
            bn_reg = bn_reg + 4'h1;
            if (bn_reg <= 4'h8) sh_reg = {sh_reg[6:0], sda};
            else nak_reg = sda;
        end
    end

    // SDA moves with SCL low; low address bits pick the page
    always @(negedge scl) begin
        if (ph_reg != 2'h3) begin
            if (bn_reg == 4'h8) begin
                if (ph_reg == 2'h0) begin
                    sel_reg = (sh_reg[7:4] == 4'ha);
                    rd_reg = sh_reg[0];
                    ptr_reg[10:8] = sh_reg[3:1];
                    sda_pull = sel_reg;
                    ph_reg = sh_reg[0] ? 2'h2 : 2'h1;
                end else if (!rd_reg && sel_reg) begin
                    ptr_reg[7:0] = sh_reg;
                    sda_pull = 1'b1;
                    ph_reg = 2'h2;
                end else begin
                    sda_pull = 1'b0;
                end
            end else if (bn_reg == 4'h9) begin
                bn_reg = 4'h0;
                sda_pull = 1'b0;
                if (rd_reg && sel_reg && !nak_reg) begin
                    cur_reg = mem[ptr_reg];
                    ptr_reg = ptr_reg + 11'h001;
                    sda_pull = !cur_reg[7];
                end
            end else if (rd_reg && sel_reg && !nak_reg) begin
                sda_pull = !cur_reg[3'(4'h7 - bn_reg)];
            end
        end
    end

    // Slow mode stretches SCL low
    always @(negedge scl) begin
        if (slow) begin
            scl_hold <= 1'b1;
            #400 scl_hold <= 1'b0;
        end
    end
endmodule : ibl_eeprom_model

// [verif/ibl_boot_ctrl_test.sv]
`timescale 1ns/1ps
module ibl_boot_ctrl_test;
    import ibl_pkg::*;
    typedef struct packed {
        logic [19:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } ibl_row_t;
    localparam logic [63:0] RECS [3] = '{64'h0000_1000_1122_3344, 64'h0000_2000_cafe_0001, 64'h0000_3000_55aa_55aa};
    localparam ibl_row_t ROWS [5] = '{
        '{CTL_OFF, 32'h1003_0000, 32'h1003_0000}, '{CTL_OFF, 32'h0000_0000, 32'h0003_0000},
        '{CTL_OFF, 32'hffff_ffff, 32'hf07f_ffff}, '{CTL_OFF, 32'h8000_0000, 32'h8003_0000},
        '{20'h1_d148, 32'h1234_5678, 32'h0000_0000}};

    logic        clk = 1'b0;
    logic        rst_n, reg_wr, reg_rd, cfg_valid, cfg_ready, boot_busy, boot_done, slow;
    logic [19:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cfg_addr, cfg_data;
    logic [1:0]  strap;
    logic        scl_out, scl_oe_n, sda_out, sda_oe_n, sda_pull, scl_hold;
    wire logic   scl_w = scl_oe_n & ~scl_hold;
    wire logic   sda_w = sda_oe_n & ~sda_pull;
    logic [63:0] got_q [$];
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;

    ibl_boot_ctrl #(.QTR_CYCLES(8)) ibl_boot_ctrl_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .boot_addr_strap(strap), .scl_in(scl_w), .scl_out, .scl_oe_n, .sda_in(sda_w), .sda_out,
        .sda_oe_n, .cfg_valid, .cfg_ready, .cfg_addr, .cfg_data, .boot_busy, .boot_done);
    ibl_eeprom_model ibl_eeprom_model_inst (.scl(scl_w), .sda(sda_w), .slow, .sda_pull, .scl_hold);

    always #12.5 clk = ~clk;

    // Watchdog
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    // Record collector
    always @(posedge clk) begin
        if (cfg_valid === 1'b1 && cfg_ready === 1'b1) got_q.push_back({cfg_addr, cfg_data});
    end

    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [19:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data taken just after the answer edge
    task automatic rd(input logic [19:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic put_rec(input int a, input logic [63:0] v);
        for (int i = 0; i < 8; i++) begin
            ibl_eeprom_model_inst.mem[a + i] = v[8*(7-i) +: 8];
        end
    endtask : put_rec

    // Buffered records drain after done
    task automatic wait_done();
        for (int i = 0; i < 40000 && boot_done !== 1'b1; i++) begin
            @(posedge clk);
        end
        repeat (20) @(posedge clk);
    endtask : wait_done

    task automatic close_out();
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////
    // Image: record 2 chains to 0xf8; next record crosses the page
    initial begin
        logic [31:0] d;
        rst_n = 1'b0;
        reg_addr = 20'h0_0000;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cfg_ready = 1'b0;
        strap = 2'b00;
        slow = 1'b0;
        foreach (ibl_eeprom_model_inst.mem[i]) ibl_eeprom_model_inst.mem[i] = 8'h00;
        ibl_eeprom_model_inst.mem[1] = 8'h02;
        ibl_eeprom_model_inst.mem[249] = 8'h01;
        put_rec(2, RECS[0]);
        put_rec(10, 64'h0001_d140_a053_001f);
        put_rec(250, RECS[1]);
        put_rec(258, RECS[2]);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(CTL_OFF, d);
        chk(64'(d), 64'h2050_0000);
        for (int i = 0; i < 20000 && cfg_valid !== 1'b1; i++) @(posedge clk);
        repeat (300) @(posedge clk);
        cfg_ready <= 1'b1;
        wait_done();
        chk(64'(got_q.size()), 64'h2);
        for (int i = 0; i < 2; i++) chk(got_q[i], RECS[i]);
        rd(CTL_OFF, d);
        chk(64'(d), 64'h2050_001f);
        rd(STAT_OFF, d);
        chk(64'(d & 32'h0000_7f07), 64'h5102);
        foreach (ROWS[i]) begin
            wr(ROWS[i].addr, ROWS[i].wdata);
            rd(ROWS[i].addr, d);
            chk(64'(d), 64'(ROWS[i].exp));
        end
        repeat (20) @(posedge clk);
        chk(64'({boot_busy, boot_done}), 64'h1);
        // Second reset: strap 01, slow partner
        got_q.delete();
        strap <= 2'b01;
        slow <= 1'b1;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wait_done();
        chk(64'(got_q.size()), 64'h1);
        chk(got_q[0], RECS[2]);
        rd(CTL_OFF, d);
        chk(64'(d), 64'h2051_0000);
        rd(STAT_OFF, d);
        chk(64'(d & 32'h0000_7f07), 64'h5102);
        close_out();
    end
endmodule : ibl_boot_ctrl_test
